// [verilog/serial_link_pkg.sv]
// shared constants, types and helpers for both ends of the single-wire link
package serial_link_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CNT_W = 18;
    // least time before the header falling edge, in ns
    localparam int SETUP_TIME_NS = 10000;
    localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least width of the standby pulse, in us
    localparam int STANDBY_TIME_US = 600;
    localparam int STANDBY_CYCLES = (STANDBY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // slave modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_IDLE = 4'h1,
        MODE_STANDBY = 4'h2,
        MODE_ACTIVE = 4'h4,
        MODE_HOLD = 4'h8
    } mode_t;

    // reason for the last entry into idle
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_BAD_ADDR = 3'h1,
        CAUSE_BAD_CMD = 3'h2,
        CAUSE_MISSED_EDGE = 3'h3,
        CAUSE_EARLY_NOACK = 3'h4,
        CAUSE_LOW_BIT = 3'h5
    } cause_t;

    // ------------------------------------------------------------
    // master modes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_STANDBY = 5'h02,
        M_SETUP = 5'h04,
        M_XFER = 5'h08,
        M_HOLD = 5'h10
    } master_mode_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (&v) ? v : v + 18'h00001;
    endfunction

    // filtered level moves only once the second and third stage agree
    function automatic logic sync_level(input logic [SYNC_STAGES-1:0] s, input logic prev);
        sync_level = (s[1] == s[2]) ? s[1] : prev;
    endfunction

endpackage

// [verilog/serial_link_if.sv]
// shared data line joining the bus master end and the slave end
interface serial_link_if;

    // ------------------------------------------------------------
    // drivers and resolved wire
    // ------------------------------------------------------------
    logic m_out;
    logic m_oe;
    logic s_out;
    logic s_oe;
    logic line;

    // pulled high when nobody drives; a driven low always wins
    assign line = (m_oe ? m_out : 1'b1) & (s_oe ? s_out : 1'b1);

    modport master (output m_out, output m_oe, input line);
    modport slave (output s_out, output s_oe, input line);

endinterface

// [verilog/serial_slave_mode.sv]
// slave end: mode control of a slave on the shared single-wire line
//
// Summary of operation
// - idle ignores all bits until standby pulse
// - bad address or command: idle, no acknowledge
// - missed edge: idle, unless hold entry
// - early no-ack goes idle, except after address
// - standby left by falling edge after setup
// - header setup interval at least ten microseconds
// - no-ack then slave ack enters standby
// - standby pulse enters standby from any mode
// - low-power core wakes only at header start
// - master starts hold low at ack bit
// - hold left by acknowledge sequence, any phase
// - master keeps bit period across hold
// - low full bit outside ack bit: idle
// - master ends every hold with acknowledge
// - hold support optional; without it, low-bit idle
module serial_slave_mode #(
    parameter int unsigned STANDBY_CYCLES = serial_link_pkg::STANDBY_CYCLES,
    parameter bit HOLD_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // shared line
    serial_link_if.slave link,
    // bit recovery side
    input wire logic [17:0] bit_period,
    input wire logic master_ack_bit,
    input wire logic addr_bad,
    input wire logic cmd_bad,
    input wire logic noack_seen,
    input wire logic noack_after_addr,
    input wire logic seq_complete,
    input wire logic term_done,
    // acknowledge drive request
    input wire logic slave_ack_drive,
    input wire logic slave_ack_level,
    // status
    output serial_link_pkg::mode_t mode,
    output serial_link_pkg::cause_t idle_cause,
    output logic idle_entered,
    output logic standby_entered,
    output logic header_start,
    output logic core_awake,
    output logic line_level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        serial_link_pkg::mode_t mode;
        logic [serial_link_pkg::SYNC_STAGES-1:0] sync;
        logic level;
        logic [serial_link_pkg::CNT_W-1:0] high_cnt;
        logic [serial_link_pkg::CNT_W-1:0] stby_cnt;
        logic [serial_link_pkg::CNT_W-1:0] edge_cnt;
        serial_link_pkg::cause_t cause;
        logic idle_evt;
        logic stby_evt;
        logic hdr_evt;
        logic pin_out;
        logic pin_oe;
    } slave_state_t;

    localparam slave_state_t RESET_STATE = '{
        mode: serial_link_pkg::MODE_IDLE,
        sync: 3'h7,
        level: 1'b1,
        high_cnt: 18'h00000,
        stby_cnt: 18'h00000,
        edge_cnt: 18'h00000,
        cause: serial_link_pkg::CAUSE_NONE,
        idle_evt: 1'b0,
        stby_evt: 1'b0,
        hdr_evt: 1'b0,
        pin_out: 1'b1,
        pin_oe: 1'b0
    };

    localparam logic [17:0] STANDBY_LAST = 18'(STANDBY_CYCLES - 1);
    localparam logic [17:0] SETUP_LAST = 18'(serial_link_pkg::SETUP_CYCLES - 1);

    slave_state_t q;
    slave_state_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic fall;
        logic rise;
        logic edge_seen;
        logic standby_hit;
        logic bit_timeout;
        logic early_noack;
        fall = 1'b0;
        rise = 1'b0;
        edge_seen = 1'b0;
        standby_hit = 1'b0;
        bit_timeout = 1'b0;
        early_noack = 1'b0;
        d = q;
        d.idle_evt = 1'b0;
        d.stby_evt = 1'b0;
        d.hdr_evt = 1'b0;

        // three stages; only the second stage reads the first
        d.sync = {q.sync[1:0], link.line};
        d.level = serial_link_pkg::sync_level(q.sync, q.level);
        fall = q.level & ~d.level;
        rise = ~q.level & d.level;
        edge_seen = fall | rise;

        // width of the current high level, for standby pulse detection
        d.high_cnt = q.level ? serial_link_pkg::sat_inc(q.high_cnt) : 18'h00000;
        standby_hit = q.level && (q.high_cnt == STANDBY_LAST);

        // time since the last edge; a bit always carries a middle edge
        d.edge_cnt = edge_seen ? 18'h00000 : serial_link_pkg::sat_inc(q.edge_cnt);
        bit_timeout = !edge_seen && (q.edge_cnt == bit_period - 18'h00001);

        d.stby_cnt = serial_link_pkg::sat_inc(q.stby_cnt);
        early_noack = noack_seen && !seq_complete && !noack_after_addr;

        unique case (q.mode)
            serial_link_pkg::MODE_IDLE: begin
                // all traffic ignored here
                d.mode = serial_link_pkg::MODE_IDLE;
            end
            serial_link_pkg::MODE_STANDBY: begin
                // an early falling edge is ignored
                if (fall && q.stby_cnt >= SETUP_LAST) begin
                    d.mode = serial_link_pkg::MODE_ACTIVE;
                    d.edge_cnt = 18'h00000;
                    d.hdr_evt = 1'b1;
                end
            end
            serial_link_pkg::MODE_ACTIVE: begin
                if (addr_bad) begin
                    d.mode = serial_link_pkg::MODE_IDLE;
                    d.cause = serial_link_pkg::CAUSE_BAD_ADDR;
                    d.idle_evt = 1'b1;
                end else if (cmd_bad) begin
                    d.mode = serial_link_pkg::MODE_IDLE;
                    d.cause = serial_link_pkg::CAUSE_BAD_CMD;
                    d.idle_evt = 1'b1;
                end else if (early_noack) begin
                    d.mode = serial_link_pkg::MODE_IDLE;
                    d.cause = serial_link_pkg::CAUSE_EARLY_NOACK;
                    d.idle_evt = 1'b1;
                end else if (term_done) begin
                    d.mode = serial_link_pkg::MODE_STANDBY;
                    d.stby_cnt = 18'h00000;
                    d.stby_evt = 1'b1;
                end else if (bit_timeout) begin
                    if (master_ack_bit && !q.level && HOLD_SUPPORT) begin
                        // low for a whole ack bit is the hold request
                        d.mode = serial_link_pkg::MODE_HOLD;
                    end else begin
                        d.mode = serial_link_pkg::MODE_IDLE;
                        d.cause = q.level ? serial_link_pkg::CAUSE_MISSED_EDGE
                                          : serial_link_pkg::CAUSE_LOW_BIT;
                        d.idle_evt = 1'b1;
                    end
                end
            end
            serial_link_pkg::MODE_HOLD: begin
                // release starts the ack sequence; phase restarts here
                // a hold ended by no-ack is not seen here
                if (rise) begin
                    d.mode = serial_link_pkg::MODE_ACTIVE;
                    d.edge_cnt = 18'h00000;
                end
            end
            default: begin
                d.mode = serial_link_pkg::MODE_IDLE;
            end
        endcase

        // a standby pulse overrides whatever mode was current
        if (standby_hit) begin
            d.mode = serial_link_pkg::MODE_STANDBY;
            d.stby_cnt = 18'h00000;
            d.stby_evt = 1'b1;
            d.idle_evt = 1'b0;
        end

        // acknowledge drive only while a command is live
        d.pin_oe = slave_ack_drive && (d.mode == serial_link_pkg::MODE_ACTIVE);
        d.pin_out = slave_ack_level;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.s_out = q.pin_out;
    assign link.s_oe = q.pin_oe;
    assign mode = q.mode;
    assign idle_cause = q.cause;
    assign idle_entered = q.idle_evt;
    assign standby_entered = q.stby_evt;
    assign header_start = q.hdr_evt;
    // core stays asleep through standby
    assign core_awake = q.mode[2] | q.mode[3];
    assign line_level = q.level;

endmodule

// [verilog/serial_master_end.sv]
// bus master end: standby pulse, setup, bit pass-through and hold
module serial_master_end #(
    parameter int unsigned STANDBY_CYCLES = serial_link_pkg::STANDBY_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // shared line
    serial_link_if.master link,
    // command side
    input wire logic start,
    input wire logic stop,
    input wire logic [17:0] bit_period,
    input wire logic drive_en,
    input wire logic drive_level,
    input wire logic hold_req,
    // status
    output serial_link_pkg::master_mode_t mode,
    output logic xfer_ready,
    output logic hold_active,
    output logic line_level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        serial_link_pkg::master_mode_t mode;
        logic [serial_link_pkg::CNT_W-1:0] cnt;
        logic [serial_link_pkg::CNT_W-1:0] period;
        logic [serial_link_pkg::SYNC_STAGES-1:0] sync;
        logic level;
        logic pin_out;
        logic pin_oe;
    } master_state_t;

    localparam master_state_t RESET_STATE = '{
        mode: serial_link_pkg::M_IDLE,
        cnt: 18'h00000,
        period: 18'h00001,
        sync: 3'h7,
        level: 1'b1,
        pin_out: 1'b1,
        pin_oe: 1'b0
    };

    localparam logic [17:0] STANDBY_LAST = 18'(STANDBY_CYCLES - 1);
    localparam logic [17:0] SETUP_LAST = 18'(serial_link_pkg::SETUP_CYCLES - 1);

    master_state_t q;
    master_state_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync = {q.sync[1:0], link.line};
        d.level = serial_link_pkg::sync_level(q.sync, q.level);
        d.cnt = serial_link_pkg::sat_inc(q.cnt);
        unique case (q.mode)
            serial_link_pkg::M_IDLE: begin
                d.pin_oe = 1'b0;
                d.pin_out = 1'b1;
                if (start) begin
                    // period frozen for the whole command
                    d.period = bit_period;
                    d.mode = serial_link_pkg::M_STANDBY;
                    d.cnt = 18'h00000;
                    d.pin_oe = 1'b1;
                end
            end
            serial_link_pkg::M_STANDBY: begin
                if (q.cnt == STANDBY_LAST) begin
                    d.mode = serial_link_pkg::M_SETUP;
                    d.cnt = 18'h00000;
                end
            end
            serial_link_pkg::M_SETUP: begin
                // line held high for the setup interval
                if (q.cnt == SETUP_LAST) begin
                    d.mode = serial_link_pkg::M_XFER;
                end
            end
            serial_link_pkg::M_XFER: begin
                d.pin_oe = drive_en;
                d.pin_out = drive_level;
                if (stop) begin
                    d.mode = serial_link_pkg::M_IDLE;
                    d.pin_oe = 1'b0;
                    d.pin_out = 1'b1;
                end else if (hold_req) begin
                    // low from the start of the ack bit
                    d.mode = serial_link_pkg::M_HOLD;
                    d.cnt = 18'h00000;
                    d.pin_oe = 1'b1;
                    d.pin_out = 1'b0;
                end
            end
            serial_link_pkg::M_HOLD: begin
                // stop is refused here: a hold must end in an ack
                if (!hold_req && q.cnt >= q.period - 18'h00001) begin
                    // user resumes with an ack sequence
                    d.mode = serial_link_pkg::M_XFER;
                    d.pin_out = 1'b1;
                end
            end
            default: begin
                d = RESET_STATE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign link.m_out = q.pin_out;
    assign link.m_oe = q.pin_oe;
    assign mode = q.mode;
    assign xfer_ready = (q.mode == serial_link_pkg::M_XFER);
    assign hold_active = (q.mode == serial_link_pkg::M_HOLD);
    assign line_level = q.level;

endmodule

// [test/serial_link_monitor.sv]
// assertion checker for the shared single-wire line and the slave mode outputs
module serial_link_monitor #(
    parameter int unsigned STANDBY_CYCLES = serial_link_pkg::STANDBY_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // shared line
    input wire logic m_out,
    input wire logic m_oe,
    input wire logic s_out,
    input wire logic s_oe,
    input wire logic line,
    // slave status
    input wire serial_link_pkg::mode_t mode,
    input wire logic idle_entered,
    input wire logic standby_entered,
    input wire logic header_start,
    input wire logic core_awake,
    // slave command side
    input wire logic term_done
);
    timeunit 1ns;
    timeprecision 1ps;

    // two cycles of slack for where the slave starts its setup count
    localparam int SETUP_MIN = serial_link_pkg::SETUP_CYCLES - 2;

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    typedef struct packed {
        logic [17:0] high_run;
        logic [17:0] since_standby;
    } mon_state_t;
    mon_state_t st_q;
    mon_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.high_run = line ? st_q.high_run + {17'h00000, ~&st_q.high_run} : 18'h00000;
        st_d.since_standby = standby_entered ? 18'h00000 :
            st_q.since_standby + {17'h00000, ~&st_q.since_standby};
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= 36'h000000000;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_idle_quiet:
        assert property ($fell(rst) |-> mode == serial_link_pkg::MODE_IDLE && !s_oe && !m_oe)
        else $error("slave not idle and quiet after reset");
    a_idle_exit_pulse:
        assert property ((mode == serial_link_pkg::MODE_IDLE ##1
            mode != serial_link_pkg::MODE_IDLE) |-> mode == serial_link_pkg::MODE_STANDBY
            && standby_entered)
        else $error("idle left without a standby pulse");
    a_standby_pulse_len:
        // entries by valid termination carry no high pulse
        assert property (standby_entered && !$past(term_done) |->
            mode == serial_link_pkg::MODE_STANDBY && st_q.high_run >= STANDBY_CYCLES)
        else $error("standby entered without a full-length high pulse");
    a_slave_drive_active:
        assert property (s_oe |-> mode == serial_link_pkg::MODE_ACTIVE)
        else $error("slave drives the line outside active mode");
    a_idle_entry_mode:
        assert property (idle_entered |-> mode == serial_link_pkg::MODE_IDLE && !core_awake)
        else $error("idle pulse without idle mode");
    a_header_wake_up:
        assert property (header_start |-> mode == serial_link_pkg::MODE_ACTIVE && core_awake
            && $past(mode) == serial_link_pkg::MODE_STANDBY)
        else $error("header start not taken from standby");
    a_header_setup_gap:
        assert property (header_start |-> st_q.since_standby >= SETUP_MIN)
        else $error("header start before the setup interval");
    a_hold_from_active:
        assert property ((mode != serial_link_pkg::MODE_HOLD ##1
            mode == serial_link_pkg::MODE_HOLD) |-> $past(mode) == serial_link_pkg::MODE_ACTIVE
            && m_oe && !m_out)
        else $error("hold entered other than from active with the master driving low");
    a_hold_exit_active:
        assert property ((mode == serial_link_pkg::MODE_HOLD ##1
            mode != serial_link_pkg::MODE_HOLD) |-> mode == serial_link_pkg::MODE_ACTIVE)
        else $error("hold left to a mode other than active");
endmodule

// [test/test_single_wire_slave_mode_control.sv]
// self-checking bench joining the master end and the slave end over the shared line
module test_single_wire_slave_mode_control;
    timeunit 1ns;
    timeprecision 1ps;

    // standby pulse above the bit period, so a missed edge is seen first
    localparam int unsigned SB = 400;
    localparam logic [17:0] PERIOD = 18'h00100;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0, stop = 1'b0, drive_en = 1'b0, drive_level = 1'b1, hold_req = 1'b0;
    logic master_ack_bit = 1'b0, addr_bad = 1'b0, cmd_bad = 1'b0, noack_seen = 1'b0;
    logic noack_after_addr = 1'b0, seq_complete = 1'b0, term_done = 1'b0;
    logic slave_ack_drive = 1'b0, slave_ack_level = 1'b1;
    serial_link_pkg::mode_t s_mode;
    serial_link_pkg::cause_t s_cause;
    serial_link_pkg::master_mode_t m_mode;
    logic s_idle, s_stby, s_hdr, s_awake, s_lvl, m_ready, m_hold, m_lvl;
    int n_errors = 0;
    int n_checks = 0;

    initial begin
        forever #2 clock = ~clock;
    end

    // ------------------------------------------------------------
    // design ends and checker
    // ------------------------------------------------------------
    serial_link_if serial_link_if_i ();

    serial_slave_mode #(.STANDBY_CYCLES(SB), .HOLD_SUPPORT(1'b1)) serial_slave_mode_i (
        .clock(clock), .rst(rst), .link(serial_link_if_i.slave), .bit_period(PERIOD),
        .master_ack_bit(master_ack_bit), .addr_bad(addr_bad), .cmd_bad(cmd_bad),
        .noack_seen(noack_seen), .noack_after_addr(noack_after_addr),
        .seq_complete(seq_complete), .term_done(term_done),
        .slave_ack_drive(slave_ack_drive), .slave_ack_level(slave_ack_level), .mode(s_mode),
        .idle_cause(s_cause), .idle_entered(s_idle), .standby_entered(s_stby),
        .header_start(s_hdr), .core_awake(s_awake), .line_level(s_lvl));

    serial_master_end #(.STANDBY_CYCLES(SB)) serial_master_end_i (
        .clock(clock), .rst(rst), .link(serial_link_if_i.master), .start(start), .stop(stop),
        .bit_period(PERIOD), .drive_en(drive_en), .drive_level(drive_level),
        .hold_req(hold_req), .mode(m_mode), .xfer_ready(m_ready), .hold_active(m_hold),
        .line_level(m_lvl));

    serial_link_monitor #(.STANDBY_CYCLES(SB)) serial_link_monitor_i (
        .clock(clock), .rst(rst), .m_out(serial_link_if_i.m_out),
        .m_oe(serial_link_if_i.m_oe), .s_out(serial_link_if_i.s_out),
        .s_oe(serial_link_if_i.s_oe), .line(serial_link_if_i.line), .mode(s_mode),
        .idle_entered(s_idle), .standby_entered(s_stby), .header_start(s_hdr),
        .core_awake(s_awake), .term_done(term_done));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_mode(input serial_link_pkg::mode_t exp);
        n_checks++;
        if (s_mode !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, s_mode, exp);
        end
    endtask

    task automatic check_cause(input serial_link_pkg::cause_t exp);
        n_checks++;
        if (s_cause !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, s_cause, exp);
        end
    endtask

    task automatic wait_mode(input serial_link_pkg::mode_t exp, input int bound);
        int i;
        for (i = 0; i < bound && s_mode !== exp; i++) @(negedge clock);
        check_mode(exp);
        if (s_mode !== exp) final_report();
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clock);
        sig = 1'b0;
    endtask

    // release the line, standby pulse, setup, then the header fall
    task automatic go_active();
        int i;
        drive_en = 1'b0;
        drive_level = 1'b1;
        master_ack_bit = 1'b0;
        pulse(stop);
        pulse(start);
        wait_mode(serial_link_pkg::MODE_STANDBY, SB + 300);
        for (i = 0; i < 4000 && m_ready !== 1'b1; i++) @(negedge clock);
        check_bit(m_ready, 1'b1);
        if (m_ready !== 1'b1) final_report();
        // margin: the slave's setup count starts a few cycles after the master's
        repeat (40) @(negedge clock);
        drive_en = 1'b1;
        drive_level = 1'b0;
        wait_mode(serial_link_pkg::MODE_ACTIVE, 20);
        check_bit(s_awake, 1'b1);
        check_bit(s_lvl, 1'b0);
        check_bit(m_lvl, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check_mode(serial_link_pkg::MODE_IDLE);
        check_cause(serial_link_pkg::CAUSE_NONE);
        check_bit(serial_link_if_i.s_oe, 1'b0);
        pulse(cmd_bad);
        pulse(term_done);
        check_mode(serial_link_pkg::MODE_IDLE);
        go_active();
        pulse(addr_bad);
        wait_mode(serial_link_pkg::MODE_IDLE, 5);
        check_cause(serial_link_pkg::CAUSE_BAD_ADDR);
        pulse(term_done);
        check_mode(serial_link_pkg::MODE_IDLE);
        go_active();
        pulse(cmd_bad);
        wait_mode(serial_link_pkg::MODE_IDLE, 5);
        check_cause(serial_link_pkg::CAUSE_BAD_CMD);
        go_active();
        noack_after_addr = 1'b1;
        pulse(noack_seen);
        repeat (3) @(negedge clock);
        check_mode(serial_link_pkg::MODE_ACTIVE);
        noack_after_addr = 1'b0;
        pulse(noack_seen);
        wait_mode(serial_link_pkg::MODE_IDLE, 5);
        check_cause(serial_link_pkg::CAUSE_EARLY_NOACK);
        go_active();
        seq_complete = 1'b1;
        drive_level = 1'b1;
        slave_ack_drive = 1'b1;
        slave_ack_level = 1'b0;
        @(negedge clock);
        check_bit(serial_link_if_i.s_oe, 1'b1);
        check_bit(serial_link_if_i.line, 1'b0);
        slave_ack_drive = 1'b0;
        pulse(term_done);
        wait_mode(serial_link_pkg::MODE_STANDBY, 5);
        check_bit(serial_link_if_i.s_oe, 1'b0);
        seq_complete = 1'b0;
        slave_ack_level = 1'b1;
        go_active();
        drive_level = 1'b1;
        wait_mode(serial_link_pkg::MODE_IDLE, 300);
        check_cause(serial_link_pkg::CAUSE_MISSED_EDGE);
        go_active();
        wait_mode(serial_link_pkg::MODE_IDLE, 300);
        check_cause(serial_link_pkg::CAUSE_LOW_BIT);
        go_active();
        master_ack_bit = 1'b1;
        hold_req = 1'b1;
        wait_mode(serial_link_pkg::MODE_HOLD, 300);
        check_bit(m_hold, 1'b1);
        // a stop inside a hold must be refused by the master end
        pulse(stop);
        check_bit(m_mode === serial_link_pkg::M_HOLD, 1'b1);
        repeat (300) @(negedge clock);
        check_mode(serial_link_pkg::MODE_HOLD);
        drive_level = 1'b1;
        hold_req = 1'b0;
        wait_mode(serial_link_pkg::MODE_ACTIVE, 600);
        final_report();
    end
endmodule
